// File: byte_fifo.sv
`timescale 1ns/10ps
module byte_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 32
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);

	localparam int AW = $clog2(DEPTH);

	generate
		if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
			$error("byte_fifo depth must be a power of two of at least 2");
		end
	endgenerate

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0] count_reg;
	logic push;
	logic pop;

	// Full and empty come straight from the occupancy count.
	assign in_ready_out = (count_reg != (AW+1)'(DEPTH));
	assign out_valid_out = (count_reg != '0);
	assign out_data_out = mem[rd_ptr_reg];
	assign push = in_valid_in && in_ready_out;
	assign pop = out_valid_out && out_ready_in;

	// Storage is written only on an accepted push.
	always_ff @(posedge clk_in) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data_in;
		end
	end

	// Pointers and count move on push and pop.
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
			if (push && !pop) begin
				count_reg <= count_reg + 1'b1;
			end else if (pop && !push) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end

endmodule : byte_fifo

// File: client_byte_interleave_mux.sv
`timescale 1ns/10ps
// Contract
// RULE1: Client bytes go straight into payload, no rate adaptation.
// RULE2: Attached clients must be frequency locked to each other.
// RULE3: Transmitter tolerates relative client wander; tolerance is a parameter.
// RULE4: Bytes interleave round-robin into payload only, in arrival order.
// RULE5: Client frame starts align with the first frame of a multiframe.
// RULE6: First A1 of client A in bits 1-8, client B in 9-16.
// RULE7: Each byte goes out most significant bit first.
// RULE8: Every transmitted T bit is zero.
// RULE9: First frame of each multiframe carries the marker state 011.
// RULE10: Multiframe spans 202.5 frames times the client count.
// RULE11: Client A first A1 lands in bits 1-8 every multiframe.
// RULE12: Two clients give a multiframe of 405 frames.
// RULE13: Four clients give a multiframe of 810 frames.
// RULE14: Receiver hands payload bytes to clients in round-robin arrival order.
// RULE15: Receiver ignores every T bit value.
// RULE16: No deskew between separate aggregation links.
// RULE17: Receiver uses a configured multiframe length, not an inferred one.
// RULE18: Payload size and T spacing are parameters; frame counter drives sequencing.
module client_byte_interleave_mux #(
	parameter int NUM_CLIENTS = client_mux_pkg::DEF_CLIENTS,
	parameter int PAYLOAD_BITS = client_mux_pkg::DEF_PAYLOAD_BITS,
	parameter int T_SPACING = client_mux_pkg::DEF_T_SPACING,
	parameter int WANDER_BYTES = client_mux_pkg::DEF_FIFO_DEPTH
) (
	input wire logic MCLK_IN,
	input wire logic RESET_IN,
	input wire logic [NUM_CLIENTS*8-1:0] CLIENT_DATA_IN,
	input wire logic [NUM_CLIENTS-1:0] CLIENT_SOF_IN,
	input wire logic [NUM_CLIENTS-1:0] CLIENT_VALID_IN,
	output logic [NUM_CLIENTS-1:0] CLIENT_READY_OUT,
	output logic TX_BIT_OUT,
	output logic TX_TBIT_OUT,
	output logic TX_SOF_OUT,
	output logic [2:0] TX_STATE_OUT,
	output logic TX_ALIGNED_OUT,
	output logic TX_SLIP_OUT,
	input wire logic RX_BIT_IN,
	input wire logic RX_SOF_IN,
	input wire logic [2:0] RX_STATE_IN,
	output logic [7:0] RX_DATA_OUT,
	output logic [$clog2(NUM_CLIENTS)-1:0] RX_CLIENT_OUT,
	output logic RX_VALID_OUT,
	output logic RX_CLIENT_SOF_OUT,
	output logic RX_LOCKED_OUT,
	output logic RX_MF_ERR_OUT
);

	// ----------------------------------------------------------------
	// Derived sizes and elaboration checks.
	// ----------------------------------------------------------------

	localparam int NC = NUM_CLIENTS;
	localparam int CW = $clog2(NC);
	localparam int FRAME_POS = PAYLOAD_BITS + PAYLOAD_BITS / T_SPACING; // RULE18
	localparam int PW = $clog2(FRAME_POS);
	localparam int MF_FRAMES = client_mux_pkg::mf_frames(NC); // RULE10
	localparam int MW = $clog2(MF_FRAMES);

	generate
		if (NC < 2 || NC % 2 != 0 || (1 << CW) != NC) begin : g_bad_clients
			$error("client count must be an even power of two");
		end
		if (PAYLOAD_BITS % T_SPACING != 0 || T_SPACING % 8 != 0) begin : g_bad_frame
			$error("payload must split into whole T groups of whole bytes");
		end
		if ((PAYLOAD_BITS / 8) % NC != 0) begin : g_bad_slots
			$error("payload bytes per frame must divide by the client count");
		end
		if (NC == 2 && MF_FRAMES != client_mux_pkg::MF_FRAMES_TWO) begin : g_bad_mf2
			$error("two-client multiframe length is wrong");
		end
		if (NC == 4 && MF_FRAMES != client_mux_pkg::MF_FRAMES_FOUR) begin : g_bad_mf4 // RULE13
			$error("four-client multiframe length is wrong");
		end
	endgenerate

	// True where a frame position holds a T bit rather than payload.
	function automatic logic is_tbit(input logic [PW-1:0] p);
		return (int'(p) % (T_SPACING + 1)) == 0; // RULE18
	endfunction : is_tbit

	// Next client index in round-robin order.
	function automatic logic [CW-1:0] next_client(input logic [CW-1:0] c);
		return CW'(c + 1'b1);
	endfunction : next_client

	default clocking cb @(posedge MCLK_IN);
	endclocking
	default disable iff (RESET_IN);

	// ----------------------------------------------------------------
	// Client buffers absorb wander between the locked clients.
	// ----------------------------------------------------------------

	typedef enum logic {TX_ALIGN, TX_RUN} tx_state_t;

	tx_state_t tx_state_reg;
	logic [8:0] fifo_data [NC];
	logic [NC-1:0] fifo_valid;
	logic [NC-1:0] fifo_pop;
	logic [PW-1:0] tx_pos_reg;
	logic [MW-1:0] tx_mf_reg;
	logic [2:0] tx_bitc_reg;
	logic [CW-1:0] tx_sel_reg;
	logic [7:0] tx_shift_reg;
	logic tx_first_reg;
	logic tx_tpos;
	logic tx_frame_end;
	logic byte_take;
	logic head_valid;
	logic head_sof;
	logic [7:0] head_byte;
	logic all_aligned;
	logic tx_slip;

	genvar gi;
	generate
		for (gi = 0; gi < NC; gi++) begin : g_client
			byte_fifo #(
				.WIDTH(9),
				.DEPTH(WANDER_BYTES)
			) u_fifo (
				.clk_in(MCLK_IN),
				.rst_in(RESET_IN),
				.in_valid_in(CLIENT_VALID_IN[gi]),
				.in_ready_out(CLIENT_READY_OUT[gi]),
				.in_data_in({CLIENT_SOF_IN[gi], CLIENT_DATA_IN[gi*8 +: 8]}),
				.out_valid_out(fifo_valid[gi]),
				.out_ready_in(fifo_pop[gi]),
				.out_data_out(fifo_data[gi])
			); // RULE3
		end
	endgenerate

	// ----------------------------------------------------------------
	// Transmit sequencing.
	// ----------------------------------------------------------------

	// The head of the buffer whose turn it is feeds the byte slot.
	assign head_valid = fifo_valid[tx_sel_reg];
	assign head_sof = fifo_data[tx_sel_reg][8];
	assign head_byte = fifo_data[tx_sel_reg][7:0];
	assign tx_tpos = is_tbit(tx_pos_reg);
	assign tx_frame_end = (tx_pos_reg == PW'(FRAME_POS - 1));
	assign byte_take = (tx_state_reg == TX_RUN) && !tx_tpos && (tx_bitc_reg == 3'h0); // RULE4
	// A slot with nothing buffered, or a frame start out of place, loses alignment.
	assign tx_slip = byte_take && (!head_valid || (head_sof != tx_first_reg));

	// Every buffer shows a client frame start at its head.
	always_comb begin
		all_aligned = 1'b1;
		for (int i = 0; i < NC; i++) begin
			all_aligned = all_aligned && fifo_valid[i] && fifo_data[i][8];
		end
	end

	// While aligning, bytes ahead of a frame start are dropped; running, the slot owner pops.
	always_comb begin
		for (int i = 0; i < NC; i++) begin
			if (tx_state_reg == TX_ALIGN) begin
				fifo_pop[i] = fifo_valid[i] && !fifo_data[i][8]; // RULE5
			end else begin
				fifo_pop[i] = byte_take && (tx_sel_reg == CW'(i)); // RULE1
			end
		end
	end

	// Frame position and multiframe counters run freely; aligning holds the multiframe count at zero.
	always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			tx_pos_reg <= '0;
			tx_mf_reg <= '0;
		end else begin
			if (tx_frame_end) begin
				tx_pos_reg <= '0;
				if (tx_state_reg == TX_ALIGN || tx_mf_reg == MW'(MF_FRAMES - 1)) begin
					tx_mf_reg <= '0; // RULE10
				end else begin
					tx_mf_reg <= tx_mf_reg + 1'b1;
				end
			end else begin
				tx_pos_reg <= tx_pos_reg + 1'b1;
			end
		end
	end

	// Alignment state: start at a frame boundary once every client waits at a frame start.
	always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			tx_state_reg <= TX_ALIGN;
		end else if (tx_state_reg == TX_ALIGN) begin
			if (tx_frame_end && all_aligned) begin
				tx_state_reg <= TX_RUN; // RULE5
			end
		end else if (tx_slip) begin
			tx_state_reg <= TX_ALIGN;
		end
	end

	// Byte slot sequencing: bit count, client turn and first-round flag.
	always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			tx_bitc_reg <= '0;
			tx_sel_reg <= '0;
			tx_first_reg <= 1'b0;
		end else if (tx_state_reg == TX_ALIGN) begin
			tx_bitc_reg <= '0;
			tx_sel_reg <= '0; // RULE6
			tx_first_reg <= 1'b1;
		end else if (!tx_tpos) begin
			tx_bitc_reg <= tx_bitc_reg + 1'b1;
			if (byte_take) begin
				tx_sel_reg <= next_client(tx_sel_reg); // RULE4
				if (tx_sel_reg == CW'(NC - 1)) begin
					tx_first_reg <= 1'b0;
				end
			end
		end
		if (tx_state_reg == TX_RUN && tx_frame_end && tx_mf_reg == MW'(MF_FRAMES - 1)) begin
			tx_first_reg <= 1'b1; // RULE11
		end
	end

	// Remaining bits of the current byte shift out behind the MSB.
	always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			tx_shift_reg <= '0;
		end else if (byte_take) begin
			tx_shift_reg <= {head_byte[6:0], 1'b0};
		end else if (tx_state_reg == TX_RUN && !tx_tpos) begin
			tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
		end
	end

	// Link outputs are registered; T positions and idle frames carry zero.
	always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			TX_BIT_OUT <= 1'b0;
			TX_TBIT_OUT <= 1'b0;
			TX_SOF_OUT <= 1'b0;
			TX_STATE_OUT <= client_mux_pkg::STATE_PLAIN;
			TX_ALIGNED_OUT <= 1'b0;
			TX_SLIP_OUT <= 1'b0;
		end else begin
			TX_TBIT_OUT <= tx_tpos;
			TX_SOF_OUT <= (tx_pos_reg == '0);
			TX_ALIGNED_OUT <= (tx_state_reg == TX_RUN) && !tx_slip;
			TX_SLIP_OUT <= tx_slip;
			if (tx_tpos || tx_state_reg == TX_ALIGN || tx_slip) begin
				TX_BIT_OUT <= 1'b0; // RULE8
			end else if (byte_take) begin
				TX_BIT_OUT <= head_byte[7]; // RULE7
			end else begin
				TX_BIT_OUT <= tx_shift_reg[7];
			end
			if (tx_pos_reg == '0) begin
				if (tx_state_reg == TX_RUN && tx_mf_reg == '0) begin
					TX_STATE_OUT <= client_mux_pkg::STATE_MARKER; // RULE9
				end else begin
					TX_STATE_OUT <= client_mux_pkg::STATE_PLAIN;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Receive de-interleaving.
	// ----------------------------------------------------------------

	logic [PW-1:0] rx_pos_reg;
	logic [PW-1:0] rx_pos;
	logic [MW-1:0] rx_mf_reg;
	logic [2:0] rx_bitc_reg;
	logic [CW-1:0] rx_sel_reg;
	logic [6:0] rx_shift_reg;
	logic rx_first_reg;
	logic rx_marker;
	logic rx_payload;
	logic rx_byte_done;
	logic rx_lock_reg;

	// Each link is framed on its own; nothing here waits on another lane.
	assign rx_pos = RX_SOF_IN ? '0 : rx_pos_reg; // RULE16
	assign rx_marker = RX_SOF_IN && (RX_STATE_IN == client_mux_pkg::STATE_MARKER
		|| RX_STATE_IN == client_mux_pkg::STATE_MARKER_ALT);
	assign rx_payload = RX_LOCKED_OUT && !rx_marker && !is_tbit(rx_pos); // RULE15
	assign rx_byte_done = rx_payload && (rx_bitc_reg == 3'h7);
	assign RX_LOCKED_OUT = rx_lock_reg;

	// Frame position follows the incoming frame start; frames are counted per multiframe.
	always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			rx_pos_reg <= '0;
			rx_mf_reg <= '0;
			rx_lock_reg <= 1'b0;
			RX_MF_ERR_OUT <= 1'b0;
		end else begin
			rx_pos_reg <= (rx_pos == PW'(FRAME_POS - 1)) ? '0 : rx_pos + 1'b1;
			RX_MF_ERR_OUT <= 1'b0;
			if (rx_marker) begin
				rx_mf_reg <= '0;
				rx_lock_reg <= 1'b1;
				RX_MF_ERR_OUT <= rx_lock_reg && (rx_mf_reg != MW'(MF_FRAMES - 1)); // RULE17
			end else if (RX_SOF_IN) begin
				rx_mf_reg <= (rx_mf_reg == MW'(MF_FRAMES - 1)) ? '0 : rx_mf_reg + 1'b1;
				RX_MF_ERR_OUT <= rx_lock_reg && (rx_mf_reg == MW'(MF_FRAMES - 1));
			end
		end
	end

	// Payload bits gather into bytes; completed bytes go to clients in turn.
	always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			rx_bitc_reg <= '0;
			rx_sel_reg <= '0;
			rx_shift_reg <= '0;
			rx_first_reg <= 1'b0;
		end else if (rx_marker) begin
			// The marker cycle is a T position, so its bit never enters a byte.
			rx_bitc_reg <= 3'h0; // RULE15
			rx_sel_reg <= '0; // RULE14
			rx_shift_reg <= '0;
			rx_first_reg <= 1'b1;
		end else if (rx_payload) begin
			rx_bitc_reg <= rx_bitc_reg + 1'b1;
			rx_shift_reg <= {rx_shift_reg[5:0], RX_BIT_IN};
			if (rx_byte_done) begin
				rx_sel_reg <= next_client(rx_sel_reg); // RULE14
				if (rx_sel_reg == CW'(NC - 1)) begin
					rx_first_reg <= 1'b0;
				end
			end
		end
	end

	// Delivered byte with its client index and client frame start flag.
	always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			RX_DATA_OUT <= '0;
			RX_CLIENT_OUT <= '0;
			RX_VALID_OUT <= 1'b0;
			RX_CLIENT_SOF_OUT <= 1'b0;
		end else begin
			RX_VALID_OUT <= rx_byte_done;
			RX_CLIENT_SOF_OUT <= rx_byte_done && rx_first_reg;
			if (rx_byte_done) begin
				RX_DATA_OUT <= {rx_shift_reg, RX_BIT_IN};
				RX_CLIENT_OUT <= rx_sel_reg;
			end
		end
	end

	// ----------------------------------------------------------------
	// Assertions and cover points.
	// ----------------------------------------------------------------

	logic [MW:0] sva_frames_reg;
	logic sva_seen_reg;
	logic tx_marker_out;

	assign tx_marker_out = TX_SOF_OUT && (TX_STATE_OUT == client_mux_pkg::STATE_MARKER);

	// Frames seen on the link since the last marker.
	always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			sva_frames_reg <= '0;
			sva_seen_reg <= 1'b0;
		end else if (tx_marker_out) begin
			sva_frames_reg <= '0;
			sva_seen_reg <= 1'b1;
		end else if (TX_SOF_OUT) begin
			sva_frames_reg <= sva_frames_reg + 1'b1;
		end else if (TX_SLIP_OUT) begin
			sva_seen_reg <= 1'b0;
		end
	end

	tbit_zero_a: assert property (TX_TBIT_OUT |-> !TX_BIT_OUT) // RULE8
		else $error("T bit driven high");
	mf_length_a: assert property (tx_marker_out && sva_seen_reg && TX_ALIGNED_OUT // RULE12
		|-> sva_frames_reg == (MW+1)'(MF_FRAMES - 1))
		else $error("multiframe length wrong");
	marker_run_a: assert property (tx_marker_out |-> $past(tx_state_reg == TX_RUN // RULE9
		&& tx_mf_reg == '0))
		else $error("marker outside first frame");
	first_slot_a: assert property (tx_state_reg == TX_RUN && tx_pos_reg == '0 // RULE6
		&& tx_mf_reg == '0 |-> tx_sel_reg == '0 && tx_bitc_reg == 3'h0 && tx_first_reg)
		else $error("multiframe does not open with client A");
	take_order_a: assert property (byte_take && !tx_slip // RULE4
		|=> tx_sel_reg == next_client($past(tx_sel_reg)))
		else $error("transmit slot order broken");
	msb_first_a: assert property (byte_take && !tx_slip // RULE7
		|=> TX_BIT_OUT == $past(head_byte[7])
		##1 (TX_TBIT_OUT || TX_BIT_OUT == $past(head_byte[6], 2)))
		else $error("byte not sent MSB first");
	slip_exit_a: assert property (tx_slip |=> TX_SLIP_OUT && !TX_ALIGNED_OUT // RULE3
		&& tx_state_reg == TX_ALIGN)
		else $error("underrun did not force realignment");
	rx_tbit_a: assert property (RX_LOCKED_OUT && !RX_SOF_IN && is_tbit(rx_pos_reg) // RULE15
		|=> $stable(rx_bitc_reg) && $stable(rx_shift_reg))
		else $error("T bit entered received data");
	rx_order_a: assert property (rx_byte_done && !rx_marker // RULE14
		|=> RX_VALID_OUT && RX_CLIENT_OUT == $past(rx_sel_reg)
		&& rx_sel_reg == next_client($past(rx_sel_reg)))
		else $error("receive de-interleave order broken");

	marker_sent_c: cover property (tx_marker_out && sva_seen_reg);
	tx_slip_c: cover property (TX_SLIP_OUT);
	rx_client_sof_c: cover property (RX_CLIENT_SOF_OUT && RX_CLIENT_OUT == CW'(NC - 1));
	rx_mf_err_c: cover property (RX_MF_ERR_OUT);

endmodule : client_byte_interleave_mux

// File: client_byte_interleave_mux_bench.sv
`timescale 1ns/10ps
module client_byte_interleave_mux_bench;
	localparam int NC = 2;
	localparam int PB = 64;
	localparam int TS = 16;
	localparam int FB = 1620;
	localparam int MF = client_mux_pkg::MF_FRAMES_TWO;
	localparam int MFB = MF * PB / 8;

	logic clk, rst, stall, tx_bit, tx_tbit, tx_sof, tx_aligned, tx_slip;
	logic [NC*8-1:0] c_data;
	logic [NC-1:0] c_sof, c_valid, c_ready;
	logic [2:0] tx_state, rx_state;
	logic rx_bit, rx_sof, rx_valid, rx_csof, rx_locked, rx_err;
	logic [7:0] rx_data, eb, eb2;
	logic [0:0] rx_client;
	int bad_count, n_tests, pos, fidx, pbit, n_mark, n_slip, rk, n_rx, n_err, mk_age;
	bit mon_on, rx_on, rx_chk, inject, alt;

	client_source #(.NUM_CLIENTS(NC), .FRAME_BYTES(FB)) i_client_source (
		.clk_in(clk), .rst_in(rst), .stall_in(stall), .ready_in(c_ready),
		.data_out(c_data), .sof_out(c_sof), .valid_out(c_valid));

	client_byte_interleave_mux #(.NUM_CLIENTS(NC), .PAYLOAD_BITS(PB), .T_SPACING(TS),
		.WANDER_BYTES(32)) i_client_byte_interleave_mux (
		.MCLK_IN(clk), .RESET_IN(rst), .CLIENT_DATA_IN(c_data), .CLIENT_SOF_IN(c_sof),
		.CLIENT_VALID_IN(c_valid), .CLIENT_READY_OUT(c_ready), .TX_BIT_OUT(tx_bit),
		.TX_TBIT_OUT(tx_tbit), .TX_SOF_OUT(tx_sof), .TX_STATE_OUT(tx_state),
		.TX_ALIGNED_OUT(tx_aligned), .TX_SLIP_OUT(tx_slip), .RX_BIT_IN(rx_bit),
		.RX_SOF_IN(rx_sof), .RX_STATE_IN(rx_state), .RX_DATA_OUT(rx_data),
		.RX_CLIENT_OUT(rx_client), .RX_VALID_OUT(rx_valid), .RX_CLIENT_SOF_OUT(rx_csof),
		.RX_LOCKED_OUT(rx_locked), .RX_MF_ERR_OUT(rx_err));

	// ----------------------------------------------------------------
	// Helpers.
	// ----------------------------------------------------------------
	function automatic logic [7:0] exp_byte(input int c, input int m);
		return 8'(m * 8'h07 + c * 8'h5A);
	endfunction : exp_byte

	task automatic check(input bit ok, input string msg);
		n_tests++;
		if (!ok) begin
			bad_count++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask : check

	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : report_and_stop

	task automatic give_up(input bit hit, input string msg);
		if (hit) begin
			check(1'b0, msg);
			report_and_stop();
		end
	endtask : give_up

	// ----------------------------------------------------------------
	// Monitors and link loopback.
	// ----------------------------------------------------------------
	// The transmit stream is predicted bit by bit from each marker onwards.
	always @(posedge clk) begin
		if (tx_slip === 1'b1) begin
			mon_on = 0;
			n_slip++;
		end
		if (tx_sof === 1'b1) begin
			pos = 0;
			if (tx_state === client_mux_pkg::STATE_MARKER) begin
				if (mon_on) check(fidx == MF - 1, "marker spacing");
				fidx = 0;
				pbit = 0;
				mon_on = 1;
				n_mark++;
			end else begin
				fidx++;
				if (mon_on) check(tx_state === 3'h0 && fidx < MF, "frame state");
			end
		end else pos++;
		if (mon_on) begin
			check(tx_tbit === (pos % (TS + 1) == 0), "T position");
			if (tx_tbit === 1'b1) check(tx_bit === 1'b0, "T value");
			else begin
				eb = exp_byte((pbit / 8) % NC, (pbit / 8 / NC) % FB);
				check(tx_bit === eb[7 - pbit % 8], "payload bit");
				pbit++;
			end
		end
	end

	// The link is looped back with T bits set and both marker codes used.
	always @(posedge clk) begin
		rx_bit <= tx_tbit ? 1'b1 : tx_bit;
		rx_sof <= tx_sof;
		rx_state <= tx_state;
		mk_age <= mk_age + 1;
		if (tx_sof === 1'b1 && tx_state === client_mux_pkg::STATE_MARKER) begin
			mk_age <= 0;
			alt <= !alt;
			if (alt) rx_state <= client_mux_pkg::STATE_MARKER_ALT;
		end else if (tx_sof === 1'b1 && inject) begin
			rx_state <= client_mux_pkg::STATE_MARKER;
			inject <= 1'b0;
		end
	end

	// Received bytes are predicted from the first byte after each true marker.
	always @(posedge clk) begin
		if (tx_slip === 1'b1 || !rx_chk) rx_on = 0;
		if (rx_err === 1'b1) n_err++;
		if (rx_valid === 1'b1) begin
			if (mk_age >= 6 && mk_age <= 14 && rx_chk) begin
				if (rx_on) check(rk == MFB, "bytes per multiframe");
				rk = 0;
				rx_on = 1;
			end
			if (rx_on) begin
				eb2 = exp_byte(rk % NC, (rk / NC) % FB);
				check(rx_client === 1'(rk % NC) && rx_data === eb2, "rx byte");
				check(rx_csof === (rk < NC), "rx client start");
				rk++;
				n_rx++;
			end
		end
	end

	// ----------------------------------------------------------------
	// Scenarios.
	// ----------------------------------------------------------------
	task automatic test_reset();
		// Look only after two clock edges under reset, so a missed start-up reset event cannot show.
		repeat (2) @(posedge clk);
		check(c_ready === 2'h3 && tx_bit === 1'b0 && tx_aligned === 1'b0, "reset tx");
		check(rx_locked === 1'b0 && rx_valid === 1'b0, "reset rx");
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		check(tx_state === 3'h0 && tx_bit === 1'b0, "idle before align");
		$display("test_reset done");
	endtask : test_reset

	task automatic test_align();
		for (int i = 0; i < 20000 && n_mark == 0; i++) @(posedge clk);
		give_up(n_mark == 0, "no alignment");
		@(posedge clk);
		check(tx_aligned === 1'b1 && tx_slip === 1'b0, "aligned");
		$display("test_align done");
	endtask : test_align

	task automatic test_multiframe();
		int e0;
		for (int i = 0; i < 30000 && n_mark < 2; i++) @(posedge clk);
		e0 = n_err;
		for (int i = 0; i < 30000 && n_mark < 3; i++) @(posedge clk);
		give_up(n_mark < 3, "multiframes missing");
		check(rx_locked === 1'b1 && n_rx > MFB, "rx locked");
		check(n_err == e0, "false marker error");
		$display("test_multiframe done");
	endtask : test_multiframe

	task automatic test_slip();
		int s0;
		int m0;
		s0 = n_slip;
		stall <= 1'b1;
		for (int i = 0; i < 1000 && n_slip == s0; i++) @(posedge clk);
		give_up(n_slip == s0, "no slip on underrun");
		check(tx_aligned === 1'b0 && tx_bit === 1'b0, "slip state");
		stall <= 1'b0;
		m0 = n_mark;
		for (int i = 0; i < 10000 && n_mark == m0; i++) @(posedge clk);
		give_up(n_mark == m0, "no realignment");
		repeat (2000) @(posedge clk);
		check(tx_aligned === 1'b1, "realigned");
		$display("test_slip done");
	endtask : test_slip

	task automatic test_mferr();
		int e0;
		e0 = n_err;
		rx_chk <= 1'b0;
		inject <= 1'b1;
		for (int i = 0; i < 300 && n_err == e0; i++) @(posedge clk);
		check(n_err > e0, "no marker error");
		$display("test_mferr done");
	endtask : test_mferr

	// A free running clock of 100 ns period.
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// Main sequence.
	initial begin
		rst = 1'b1;
		stall = 1'b0;
		inject = 1'b0;
		rx_chk = 1'b1;
		mk_age = 100;
		rx_bit = 1'b0;
		rx_sof = 1'b0;
		rx_state = 3'h0;
		test_reset();
		test_align();
		test_multiframe();
		test_slip();
		test_mferr();
		report_and_stop();
	end
endmodule : client_byte_interleave_mux_bench

// File: client_mux_pkg.sv
package client_mux_pkg;

	// ----------------------------------------------------------------
	// Framing constants shared by the multiplexer and its testbench.
	// ----------------------------------------------------------------

	// Bits in one client byte.
	localparam int BYTE_BITS = 8;
	// Default number of aggregated clients.
	localparam int DEF_CLIENTS = 2;
	// Default payload bits in one link frame.
	localparam int DEF_PAYLOAD_BITS = 1536;
	// Default payload bits that follow each T bit.
	localparam int DEF_T_SPACING = 64;
	// Default depth of each client buffer, in bytes.
	localparam int DEF_FIFO_DEPTH = 32;
	// One client frame fills 202.5 link frames; held doubled to stay integral.
	localparam int CLIENT_FRAME_HALVES = 405;
	// Multiframe lengths for two and for four clients.
	localparam int MF_FRAMES_TWO = 405;
	localparam int MF_FRAMES_FOUR = 810;
	// Frame state codes: the alignment marker, its alternate, and a plain frame.
	localparam logic [2:0] STATE_MARKER = 3'h3;
	localparam logic [2:0] STATE_MARKER_ALT = 3'h1;
	localparam logic [2:0] STATE_PLAIN = 3'h0;

	// Multiframe length in link frames for a given client count.
	function automatic int mf_frames(input int clients);
		return clients * CLIENT_FRAME_HALVES / 2;
	endfunction : mf_frames

endpackage : client_mux_pkg

// File: client_source.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Client framer model feeding byte streams into the multiplexer.
// ----------------------------------------------------------------
module client_source #(
	parameter int NUM_CLIENTS = 2,
	parameter int FRAME_BYTES = 1620
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic stall_in,
	input wire logic [NUM_CLIENTS-1:0] ready_in,
	output logic [NUM_CLIENTS*8-1:0] data_out,
	output logic [NUM_CLIENTS-1:0] sof_out,
	output logic [NUM_CLIENTS-1:0] valid_out
);
	int cnt_reg [NUM_CLIENTS];

	// Each client counts its bytes and holds an offer until it is taken.
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_reg <= '{default: 0};
			valid_out <= '0;
		end else begin
			for (int i = 0; i < NUM_CLIENTS; i++) begin
				if (valid_out[i] && ready_in[i]) begin
					cnt_reg[i] <= (cnt_reg[i] + 1) % FRAME_BYTES;
				end
				valid_out[i] <= (valid_out[i] && !ready_in[i]) || !stall_in;
			end
		end
	end

	// Idle lines carry the inverse pattern so a stale byte is never mistaken for data.
	always_comb begin
		for (int i = 0; i < NUM_CLIENTS; i++) begin
			data_out[i*8+:8] = 8'(cnt_reg[i] * 8'h07 + i * 8'h5A) ^ {8{!valid_out[i]}};
			sof_out[i] = (cnt_reg[i] == 0) ^ !valid_out[i];
		end
	end
endmodule : client_source
